// ==== hdl/soag_addr_gen.sv ====
// module: segment selection and 16-bit offset generation for operand references
`timescale 1ns/1ns

module soag_addr_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // decoder request and register file view
    input wire soag_pkg::soag_req_t req,
    input wire soag_pkg::soag_regs_t regs,
    // to translation stage
    output soag_pkg::soag_addr_t addr,
    // operand value for register and immediate references
    output soag_pkg::soag_opnd_t opnd
);

    soag_pkg::soag_addr_t addr_r;
    soag_pkg::soag_addr_t addr_nxt;
    soag_pkg::soag_opnd_t opnd_r;
    soag_pkg::soag_opnd_t opnd_nxt;
    logic [15:0] disp_ext;
    logic [15:0] base_val;
    logic [15:0] index_val;
    logic [15:0] rind_val;
    logic [15:0] ea;
    soag_pkg::soag_seg_t implicit_seg;
    logic base_used_ptr;

    always_comb begin
        // short displacement extended from its sign bit
        if (req.disp_is_16) begin
            disp_ext = req.disp;
        end else begin
            disp_ext = {{8{req.disp[soag_pkg::DISP8_SIGN_BIT]}}, req.disp[7:0]};
        end
        base_val = req.base_is_ptr ? regs.base_pointer_reg : regs.base_word_reg;
        index_val = req.index_is_dest ? regs.dest_index_reg : regs.src_index_reg;
        case (req.rind_sel)
            soag_pkg::SOAG_RI_SRC_INDEX: rind_val = regs.src_index_reg;
            soag_pkg::SOAG_RI_DEST_INDEX: rind_val = regs.dest_index_reg;
            soag_pkg::SOAG_RI_BASE_WORD: rind_val = regs.base_word_reg;
            default: rind_val = regs.base_pointer_reg;
        endcase
        // 16-bit sums wrap; no carry leaves the segment
        case (req.mode)
            soag_pkg::SOAG_AM_DIRECT: begin
                ea = disp_ext;
                base_used_ptr = 1'b0;
            end
            soag_pkg::SOAG_AM_REGIND: begin
                ea = rind_val;
                base_used_ptr = (req.rind_sel == soag_pkg::SOAG_RI_BASE_POINTER);
            end
            soag_pkg::SOAG_AM_BASED: begin
                ea = 16'(disp_ext + base_val);
                base_used_ptr = req.base_is_ptr;
            end
            soag_pkg::SOAG_AM_INDEXED: begin
                ea = 16'(disp_ext + index_val);
                base_used_ptr = 1'b0;
            end
            soag_pkg::SOAG_AM_BIDX: begin
                ea = 16'(base_val + index_val);
                base_used_ptr = req.base_is_ptr;
            end
            soag_pkg::SOAG_AM_BIDX_DISP: begin
                ea = 16'(base_val + index_val + disp_ext);
                base_used_ptr = req.base_is_ptr;
            end
            default: begin
                ea = soag_pkg::OFFSET_RST;
                base_used_ptr = 1'b0;
            end
        endcase
    end

    always_comb begin
        // implicit segment by reference kind
        case (req.kind)
            soag_pkg::SOAG_REF_STACK: implicit_seg = soag_pkg::SOAG_SEG_STACK;
            soag_pkg::SOAG_REF_STRDST: implicit_seg = soag_pkg::SOAG_SEG_EXTRA;
            soag_pkg::SOAG_REF_DATA: begin
                if (base_used_ptr) begin
                    implicit_seg = soag_pkg::SOAG_SEG_STACK;
                end else begin
                    implicit_seg = soag_pkg::SOAG_SEG_DATA;
                end
            end
            default: implicit_seg = soag_pkg::SOAG_SEG_CODE;
        endcase
    end

    always_comb begin
        addr_nxt = addr_r;
        opnd_nxt = opnd_r;
        addr_nxt.valid = 1'b0;
        opnd_nxt.valid = 1'b0;
        if (req.valid) begin
            case (req.kind)
                soag_pkg::SOAG_REF_FETCH: begin
                    // override ignored for prefetch
                    addr_nxt.valid = 1'b1;
                    addr_nxt.is_mem = 1'b1;
                    addr_nxt.seg = soag_pkg::SOAG_SEG_CODE;
                    addr_nxt.offset = req.fetch_offset;
                end
                soag_pkg::SOAG_REF_REGOP: begin
                    opnd_nxt.valid = 1'b1;
                    addr_nxt.is_mem = 1'b0;
                    if (req.gpr_is_8) begin
                        opnd_nxt.value = {8'h00, req.gpr_value[7:0]};
                    end else begin
                        opnd_nxt.value = req.gpr_value;
                    end
                end
                soag_pkg::SOAG_REF_IMMOP: begin
                    opnd_nxt.valid = 1'b1;
                    addr_nxt.is_mem = 1'b0;
                    opnd_nxt.value = req.imm_value;
                end
                default: begin
                    addr_nxt.valid = 1'b1;
                    addr_nxt.is_mem = 1'b1;
                    addr_nxt.offset = ea;
                    if (req.kind == soag_pkg::SOAG_REF_DATA && req.ovr_valid) begin
                        addr_nxt.seg = req.ovr_seg;
                    end else if (req.ovr_valid && req.kind == soag_pkg::SOAG_REF_STACK) begin
                        addr_nxt.seg = implicit_seg;
                    end else begin
                        addr_nxt.seg = implicit_seg;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_r <= '{valid: 1'b0, is_mem: 1'b0, seg: soag_pkg::SOAG_SEG_CODE,
                        offset: soag_pkg::OFFSET_RST};
            opnd_r <= '{valid: 1'b0, value: soag_pkg::OPERAND_RST};
        end else begin
            addr_r <= addr_nxt;
            opnd_r <= opnd_nxt;
        end
    end

    assign addr = addr_r;
    assign opnd = opnd_r;

    AST_FETCH_CODE: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_FETCH) |=>
        (addr.valid && addr.seg == soag_pkg::SOAG_SEG_CODE &&
         addr.offset == $past(req.fetch_offset)))
        else $error("prefetch did not use code segment");

    AST_STACK_SEG: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_STACK) |=>
        (addr.seg == soag_pkg::SOAG_SEG_STACK))
        else $error("stack reference not in stack segment");

    AST_BP_STACK: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA && !req.ovr_valid && req.base_is_ptr &&
         (req.mode == soag_pkg::SOAG_AM_BASED || req.mode == soag_pkg::SOAG_AM_BIDX)) |=>
        (addr.seg == soag_pkg::SOAG_SEG_STACK))
        else $error("base pointer reference not in stack segment");

    AST_DATA_SEG: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA && !req.ovr_valid &&
         req.mode == soag_pkg::SOAG_AM_DIRECT) |=> (addr.seg == soag_pkg::SOAG_SEG_DATA))
        else $error("plain data reference not in data segment");

    AST_STRDST_SEG: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_STRDST) |=>
        (addr.seg == soag_pkg::SOAG_SEG_EXTRA))
        else $error("string destination not in extra segment");

    AST_OVERRIDE: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA && req.ovr_valid) |=>
        (addr.seg == $past(req.ovr_seg)))
        else $error("override prefix not honoured");

    AST_REGOP_NOMEM: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_REGOP) |=> (!addr.valid && opnd.valid))
        else $error("register operand caused memory reference");

    AST_IMM_VALUE: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_IMMOP) |=>
        (opnd.valid && opnd.value == $past(req.imm_value)))
        else $error("immediate operand value wrong");

    AST_DIRECT_SEXT: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA &&
         req.mode == soag_pkg::SOAG_AM_DIRECT && !req.disp_is_16) |=>
        (addr.offset == {{8{$past(req.disp[7])}}, $past(req.disp[7:0])}))
        else $error("short displacement not sign-extended");

    AST_BIDX_SUM: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA && req.mode == soag_pkg::SOAG_AM_BIDX &&
         !req.base_is_ptr && !req.index_is_dest) |=>
        (addr.offset == 16'($past(regs.base_word_reg) + $past(regs.src_index_reg))))
        else $error("based indexed sum wrong");

    AST_DATA_IDX_SEG: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA && !req.ovr_valid &&
         req.mode == soag_pkg::SOAG_AM_INDEXED) |=>
        (addr.seg == soag_pkg::SOAG_SEG_DATA))
        else $error("indexed data reference not in data segment");

    AST_REGIND_PTR: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA && !req.ovr_valid &&
         req.mode == soag_pkg::SOAG_AM_REGIND &&
         req.rind_sel == soag_pkg::SOAG_RI_BASE_POINTER) |=>
        (addr.seg == soag_pkg::SOAG_SEG_STACK &&
         addr.offset == $past(regs.base_pointer_reg)))
        else $error("base pointer indirect reference wrong");

    AST_REGIND_SRC: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA &&
         req.mode == soag_pkg::SOAG_AM_REGIND &&
         req.rind_sel == soag_pkg::SOAG_RI_SRC_INDEX) |=>
        (addr.offset == $past(regs.src_index_reg)))
        else $error("register indirect offset wrong");

    AST_DIRECT_WIDE: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA &&
         req.mode == soag_pkg::SOAG_AM_DIRECT && req.disp_is_16) |=>
        (addr.offset == $past(req.disp)))
        else $error("direct offset differs from displacement");

    AST_BASED_SUM: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA &&
         req.mode == soag_pkg::SOAG_AM_BASED && req.disp_is_16 && !req.base_is_ptr) |=>
        (addr.offset == 16'($past(req.disp) + $past(regs.base_word_reg))))
        else $error("based offset sum wrong");

    AST_INDEXED_SUM: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA &&
         req.mode == soag_pkg::SOAG_AM_INDEXED && req.disp_is_16 && req.index_is_dest) |=>
        (addr.offset == 16'($past(req.disp) + $past(regs.dest_index_reg))))
        else $error("indexed offset sum wrong");

    AST_INDEXED_SHORT: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA &&
         req.mode == soag_pkg::SOAG_AM_INDEXED && !req.disp_is_16 && !req.index_is_dest) |=>
        (addr.offset == 16'({{8{$past(req.disp[7])}}, $past(req.disp[7:0])} +
                            $past(regs.src_index_reg))))
        else $error("short displacement plus index wrong");

    AST_BIDX_DISP_SUM: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA &&
         req.mode == soag_pkg::SOAG_AM_BIDX_DISP && req.disp_is_16 &&
         req.base_is_ptr && !req.index_is_dest) |=>
        (addr.offset == 16'($past(regs.base_pointer_reg) + $past(regs.src_index_reg) +
                            $past(req.disp))))
        else $error("based indexed displacement sum wrong");

    AST_OFFSET_WRAP: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_DATA &&
         req.mode == soag_pkg::SOAG_AM_BIDX_DISP && req.disp_is_16 &&
         !req.base_is_ptr && req.index_is_dest) |=>
        (addr.offset == 16'($past(regs.base_word_reg) + $past(regs.dest_index_reg) +
                            $past(req.disp))))
        else $error("offset sum did not wrap at 16 bits");

    AST_REF_PAIR: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind != soag_pkg::SOAG_REF_REGOP &&
         req.kind != soag_pkg::SOAG_REF_IMMOP) |=>
        (addr.valid && addr.is_mem && !opnd.valid))
        else $error("memory reference not presented");

    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!rstn)
        !req.valid |=> (!addr.valid && !opnd.valid))
        else $error("answer without request");

    AST_IMM_NOMEM: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.kind == soag_pkg::SOAG_REF_IMMOP) |=>
        (!addr.valid && !addr.is_mem))
        else $error("immediate operand caused memory reference");

    AST_SEG_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        (!req.valid || req.kind == soag_pkg::SOAG_REF_REGOP ||
         req.kind == soag_pkg::SOAG_REF_IMMOP) |=>
        ($stable(addr.seg) && $stable(addr.offset)))
        else $error("selector or offset changed without reference");

endmodule // soag_addr_gen

// ==== hdl/soag_pkg.sv ====
// package: shared types and constants for the segment/offset address generator
package soag_pkg;

    localparam int ADDR_W = 16;
    localparam int SEG_SPAN_BYTES = 65536;
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [15:0] OPERAND_RST = 16'h0000;
    localparam int DISP8_SIGN_BIT = 7;

    // segment register identities
    typedef enum logic [1:0] {
        SOAG_SEG_EXTRA = 2'b00,
        SOAG_SEG_CODE = 2'b01,
        SOAG_SEG_STACK = 2'b10,
        SOAG_SEG_DATA = 2'b11
    } soag_seg_t;

    // kind of reference asked for by the decoder
    typedef enum logic [2:0] {
        SOAG_REF_FETCH = 3'b000,
        SOAG_REF_STACK = 3'b001,
        SOAG_REF_DATA = 3'b010,
        SOAG_REF_STRDST = 3'b011,
        SOAG_REF_REGOP = 3'b100,
        SOAG_REF_IMMOP = 3'b101
    } soag_ref_t;

    // memory addressing modes
    typedef enum logic [2:0] {
        SOAG_AM_DIRECT = 3'b000,
        SOAG_AM_REGIND = 3'b001,
        SOAG_AM_BASED = 3'b010,
        SOAG_AM_INDEXED = 3'b011,
        SOAG_AM_BIDX = 3'b100,
        SOAG_AM_BIDX_DISP = 3'b101
    } soag_mode_t;

    // register selects: base word or base pointer, source or dest index
    typedef enum logic [1:0] {
        SOAG_RI_SRC_INDEX = 2'b00,
        SOAG_RI_DEST_INDEX = 2'b01,
        SOAG_RI_BASE_WORD = 2'b10,
        SOAG_RI_BASE_POINTER = 2'b11
    } soag_rind_t;

    typedef struct packed {
        logic valid;
        soag_ref_t kind;
        soag_mode_t mode;
        logic base_is_ptr;
        logic index_is_dest;
        soag_rind_t rind_sel;
        logic disp_is_16;
        logic [15:0] disp;
        logic ovr_valid;
        soag_seg_t ovr_seg;
        logic [15:0] fetch_offset;
        logic [15:0] imm_value;
        logic [15:0] gpr_value;
        logic gpr_is_8;
    } soag_req_t;

    typedef struct packed {
        logic [15:0] base_word_reg;
        logic [15:0] base_pointer_reg;
        logic [15:0] src_index_reg;
        logic [15:0] dest_index_reg;
    } soag_regs_t;

    typedef struct packed {
        logic valid;
        logic is_mem;
        soag_seg_t seg;
        logic [15:0] offset;
    } soag_addr_t;

    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } soag_opnd_t;

endpackage

// ==== bench/soag_xlate_model.sv ====
// translation stage model: takes each memory reference and counts it
`timescale 1ns/1ns
module soag_xlate_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // from the address generator
    input wire soag_pkg::soag_addr_t addr,
    // references taken so far
    output logic [15:0] n_refs
);
    logic [15:0] n_refs_r;
    logic [15:0] n_refs_nxt;

    // a reference is counted on each cycle where valid and is_mem are both set
    always_comb begin
        n_refs_nxt = n_refs_r + {15'h0000, addr.valid & addr.is_mem};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            n_refs_r <= 16'h0000;
        end else begin
            n_refs_r <= n_refs_nxt;
        end
    end

    assign n_refs = n_refs_r;
endmodule // soag_xlate_model

// ==== bench/soag_addr_gen_tb_top.sv ====
// testbench: drives the address generator and judges its answers
`timescale 1ns/1ns
module soag_addr_gen_tb_top;
    logic clk;
    logic rstn;
    soag_pkg::soag_req_t req;
    soag_pkg::soag_regs_t regs;
    soag_pkg::soag_addr_t addr;
    soag_pkg::soag_opnd_t opnd;
    logic [15:0] n_refs;
    int miscompares;
    int cmp_count;

    soag_addr_gen u_soag_addr_gen (.clk(clk), .rstn(rstn), .req(req), .regs(regs),
        .addr(addr), .opnd(opnd));
    soag_xlate_model u_soag_xlate_model (.clk(clk), .rstn(rstn), .addr(addr),
        .n_refs(n_refs));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_seg(input string name, input logic [1:0] exp, input logic [1:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held over one edge, answer looked at 1 ns after that same edge
    task automatic send(input soag_pkg::soag_req_t r, input logic mem);
        req = r;
        @(posedge clk);
        #1;
        chk_val("addr_valid", {15'h0000, mem}, {15'h0000, addr.valid});
        chk_val("addr_is_mem", {15'h0000, mem}, {15'h0000, addr.is_mem});
        chk_val("opnd_valid", {15'h0000, ~mem}, {15'h0000, opnd.valid});
    endtask

    task automatic idle();
        req.valid = 1'b0;
        @(posedge clk);
        #1;
        chk_val("valid_drop", 16'h0000, {14'h0000, addr.valid, opnd.valid});
    endtask

    // all six modes, both displacement widths, back to back
    task automatic t_modes();
        soag_pkg::soag_req_t r;
        soag_pkg::soag_seg_t seg_exp;
        logic [15:0] d_ext;
        logic [15:0] b;
        logic [15:0] x;
        logic [15:0] e;
        logic stk;
        regs = {16'hFFF0, 16'h0020, 16'h8000, 16'h0011};
        for (int i = 0; i < 24; i++) begin
            r = '0;
            r.valid = 1'b1;
            r.kind = soag_pkg::SOAG_REF_DATA;
            r.mode = soag_pkg::soag_mode_t'(i / 4);
            r.disp_is_16 = i[0];
            r.base_is_ptr = i[1];
            r.index_is_dest = i[1] ^ i[0];
            r.rind_sel = soag_pkg::soag_rind_t'(i[1:0]);
            r.disp = 16'h7F80;
            d_ext = r.disp_is_16 ? r.disp : {{8{r.disp[7]}}, r.disp[7:0]};
            b = r.base_is_ptr ? regs.base_pointer_reg : regs.base_word_reg;
            x = r.index_is_dest ? regs.dest_index_reg : regs.src_index_reg;
            case (i / 4)
                0: e = d_ext;
                1: e = i[1] ? (i[0] ? regs.base_pointer_reg : regs.base_word_reg)
                            : (i[0] ? regs.dest_index_reg : regs.src_index_reg);
                2: e = 16'(d_ext + b);
                3: e = 16'(d_ext + x);
                4: e = 16'(b + x);
                default: e = 16'(d_ext + b + x);
            endcase
            // base pointer as base register means the stack segment
            stk = (i / 4 == 1) ? (i[1:0] == 2'b11) : (r.base_is_ptr && (i / 4) inside {2, 4, 5});
            seg_exp = stk ? soag_pkg::SOAG_SEG_STACK : soag_pkg::SOAG_SEG_DATA;
            send(r, 1'b1);
            case (i / 4)
                0: chk_val("direct_off", e, addr.offset);
                1: chk_val("regind_off", e, addr.offset);
                2: chk_val("based_off", e, addr.offset);
                3: chk_val("indexed_off", e, addr.offset);
                4: chk_val("bidx_off", e, addr.offset);
                default: chk_val("bidx_disp_off", e, addr.offset);
            endcase
            chk_seg("seg", seg_exp, addr.seg);
        end
        idle();
        $display("test modes done");
    endtask

    // implicit segments against an override prefix
    task automatic t_segs();
        soag_pkg::soag_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.mode = soag_pkg::SOAG_AM_BASED;
        r.base_is_ptr = 1'b1;
        r.ovr_valid = 1'b1;
        r.ovr_seg = soag_pkg::SOAG_SEG_DATA;
        r.kind = soag_pkg::SOAG_REF_FETCH;
        r.fetch_offset = 16'hBEEF;
        send(r, 1'b1);
        chk_seg("fetch_seg", soag_pkg::SOAG_SEG_CODE, addr.seg);
        chk_val("fetch_off", 16'hBEEF, addr.offset);
        r.kind = soag_pkg::SOAG_REF_STACK;
        send(r, 1'b1);
        chk_seg("stack_seg", soag_pkg::SOAG_SEG_STACK, addr.seg);
        r.kind = soag_pkg::SOAG_REF_STRDST;
        send(r, 1'b1);
        chk_seg("strdst_seg", soag_pkg::SOAG_SEG_EXTRA, addr.seg);
        r.kind = soag_pkg::SOAG_REF_DATA;
        for (int s = 0; s < 4; s++) begin
            r.ovr_seg = soag_pkg::soag_seg_t'(s);
            send(r, 1'b1);
            chk_seg("ovr_seg", s[1:0], addr.seg);
        end
        idle();
        $display("test segments done");
    endtask

    task automatic t_opnd();
        soag_pkg::soag_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.kind = soag_pkg::SOAG_REF_REGOP;
        r.gpr_value = 16'hABCD;
        send(r, 1'b0);
        chk_val("reg16", 16'hABCD, opnd.value);
        r.gpr_is_8 = 1'b1;
        send(r, 1'b0);
        chk_val("reg8", 16'h00CD, opnd.value);
        r.kind = soag_pkg::SOAG_REF_IMMOP;
        r.imm_value = 16'h5A5A;
        send(r, 1'b0);
        chk_val("imm", 16'h5A5A, opnd.value);
        idle();
        $display("test operands done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        finish_test();
    end

    initial begin
        miscompares = 0;
        cmp_count = 0;
        rstn = 1'b0;
        req = '0;
        regs = '0;
        repeat (16) @(posedge clk);
        #1;
        chk_val("rst_valid", 16'h0000, {14'h0000, addr.valid, opnd.valid});
        chk_seg("rst_seg", soag_pkg::SOAG_SEG_CODE, addr.seg);
        chk_val("rst_off", 16'h0000, addr.offset);
        rstn = 1'b1;
        t_modes();
        t_segs();
        t_opnd();
        chk_val("refs", 16'h001F, n_refs);
        finish_test();
    end
endmodule // soag_addr_gen_tb_top
